/* pkg/srsr_pkg.sv */
// shared constants and carriers for the result and status register bank
package srsr_pkg;

  // register offsets on the byte-wide register port
  localparam logic [7:0] ADDR_PROX2_RESULT_HIGH      = 8'h29;
  localparam logic [7:0] ADDR_PROX3_RESULT_LOW       = 8'h2a;
  localparam logic [7:0] ADDR_PROX3_RESULT_HIGH      = 8'h2b;
  localparam logic [7:0] ADDR_AUX_RESULT_LOW         = 8'h2c;
  localparam logic [7:0] ADDR_AUX_RESULT_HIGH        = 8'h2d;
  localparam logic [7:0] ADDR_PARAM_READBACK_MAILBOX = 8'h2e;
  localparam logic [7:0] ADDR_CHIP_POWER_STATE       = 8'h30;

  // first offset of the bank and number of byte slots it spans
  localparam logic [7:0] ADDR_BASE  = 8'h29;
  localparam int         BANK_DEPTH = 8;

  // memory slot indices (offset minus base)
  localparam logic [2:0] SLOT_PROX2_HIGH = 3'h0;
  localparam logic [2:0] SLOT_PROX3_LOW  = 3'h1;
  localparam logic [2:0] SLOT_PROX3_HIGH = 3'h2;
  localparam logic [2:0] SLOT_AUX_LOW    = 3'h3;
  localparam logic [2:0] SLOT_AUX_HIGH   = 3'h4;
  localparam logic [2:0] SLOT_MAILBOX    = 3'h5;

  // chip power state field positions
  localparam int BIT_AWAKE   = 2;
  localparam int BIT_SUSPEND = 1;
  localparam int BIT_SLEEP   = 0;

  // reset value of every byte in the bank
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // power state reported by the sequencer
  typedef enum logic [1:0] {
    SRSR_PWR_OFF     = 2'b00,
    SRSR_PWR_SLEEP   = 2'b01,
    SRSR_PWR_SUSPEND = 2'b10,
    SRSR_PWR_AWAKE   = 2'b11
  } srsr_pwr_e;

  // host register access request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } srsr_host_req_s;

  // results posted by the measurement engine
  typedef struct packed {
    logic        prox2_valid;
    logic [15:0] prox2_result;
    logic        prox3_valid;
    logic [15:0] prox3_result;
    logic        aux_valid;
    logic [15:0] aux_result;
  } srsr_results_s;

  // slot number of an offset inside the bank
  function automatic logic [2:0] slot_of(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - ADDR_BASE;
    return diff[2:0];
  endfunction

  // offset lies on one of the memory-backed bytes
  function automatic logic in_mem(input logic [7:0] addr);
    return (addr >= ADDR_PROX2_RESULT_HIGH) && (addr <= ADDR_PARAM_READBACK_MAILBOX);
  endfunction

endpackage

/* design/srsr_byte_mem.sv */
`timescale 1ns/1ns
`default_nettype none
// small byte memory with one write port and a registered read port
module srsr_byte_mem #(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic          sys_clk,   // system clock
  input  wire logic          reset,     // synchronous reset, clears all bytes
  input  wire logic          wr_en,     // write strobe
  input  wire logic [AW-1:0] wr_addr,   // write slot
  input  wire logic [7:0]    wr_data,   // write byte
  input  wire logic [AW-1:0] rd_addr,   // read slot
  output logic      [7:0]    rd_data    // registered read byte
);

  logic [7:0] mem [DEPTH];  // storage

  // write port, cleared on reset so every byte reads zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= srsr_pkg::RESET_BYTE;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read port, data appear one cycle after the address
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_data <= srsr_pkg::RESET_BYTE;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

/* design/srsr_regs.sv */
// Function
// - prox2 result bits 15:8 at 0x29
// - prox3 result word at 0x2A/0x2B
// - aux result word at 0x2C/0x2D
// - mailbox byte at 0x2E from sequencer
// - state bit2 awake, bit1 suspend
// - state bit0 sleep, bits 7:3 reserved
// - memory bytes read zero after reset; state byte follows power_state from the first edge
`timescale 1ns/1ns
`default_nettype none
module srsr_regs (
  input  wire logic                     sys_clk,         // system clock, 50 MHz
  input  wire logic                     reset,           // synchronous reset, active high
  input  wire srsr_pkg::srsr_host_req_s host_req,        // host register access
  input  wire srsr_pkg::srsr_results_s  results,         // fresh measurement results
  input  wire logic                     mailbox_wr,      // sequencer posts a parameter value
  input  wire logic [7:0]               mailbox_data,    // value posted by the sequencer
  input  wire srsr_pkg::srsr_pwr_e      power_state,     // sequencer power state
  output logic      [7:0]               host_rdata,      // read byte
  output logic                          host_rvalid      // read byte valid, one-cycle pulse
);

  logic [2:0] wr_slot;        // slot chosen for the memory write
  logic [7:0] wr_byte;        // byte written into the memory
  logic       wr_go;          // memory write strobe
  logic [7:0] mem_rdata;      // registered memory read data
  logic [7:0] chip_power_state; // chip state byte, read only
  logic       rd_pend;        // read issued last cycle
  logic [1:0] rd_kind;        // source of pending read: 0 none, 1 memory, 2 state
  logic       host_mem_wr;    // host write to a memory byte
  logic [2:0] res_step;       // slot served by the result write sequencer
  logic [4:0] res_pend;       // result bytes waiting to be stored, one bit per slot
  logic [4:0] res_new;        // result bytes made pending by this cycle's posts
  logic [4:0] res_done;       // result byte stored this cycle
  srsr_pkg::srsr_results_s res_hold; // latched results awaiting storage

  // host writes land on memory bytes; result bytes are writable as documented
  assign host_mem_wr = host_req.wr && srsr_pkg::in_mem(host_req.addr);

  // result words latched on their valid pulse, stored byte by byte later
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      res_hold <= '0;
    end else begin
      res_hold.prox2_valid <= results.prox2_valid;
      res_hold.prox3_valid <= results.prox3_valid;
      res_hold.aux_valid   <= results.aux_valid;
      if (results.prox2_valid) res_hold.prox2_result <= results.prox2_result;
      if (results.prox3_valid) res_hold.prox3_result <= results.prox3_result;
      if (results.aux_valid) res_hold.aux_result <= results.aux_result;
    end
  end

  // bytes made pending by a post, ordered by slot number
  always_comb begin
    res_new = {results.aux_valid, results.aux_valid, results.prox3_valid,
               results.prox3_valid, results.prox2_valid};
  end

  // pending bytes; a new post wins over the store of the same slot
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      res_pend <= '0;
    end else begin
      res_pend <= (res_pend & ~res_done) | res_new;
    end
  end

  // result step counter walks round the five result slots
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      res_step <= srsr_pkg::SLOT_PROX2_HIGH;
    end else if (res_step == srsr_pkg::SLOT_AUX_HIGH) begin
      res_step <= srsr_pkg::SLOT_PROX2_HIGH;
    end else begin
      res_step <= res_step + 3'h1;
    end
  end

  // select the byte to write this cycle; hardware posts beat a host write
  always_comb begin
    wr_go    = 1'b0;
    wr_slot  = srsr_pkg::SLOT_PROX2_HIGH;
    wr_byte  = srsr_pkg::RESET_BYTE;
    res_done = '0;
    if (mailbox_wr) begin
      wr_go   = 1'b1;
      wr_slot = srsr_pkg::SLOT_MAILBOX;
      wr_byte = mailbox_data;
    end else if (res_pend[res_step]) begin
      wr_go              = 1'b1;
      wr_slot            = res_step;
      res_done[res_step] = 1'b1;
      case (res_step)
        srsr_pkg::SLOT_PROX2_HIGH: wr_byte = res_hold.prox2_result[15:8];
        srsr_pkg::SLOT_PROX3_LOW:  wr_byte = res_hold.prox3_result[7:0];
        srsr_pkg::SLOT_PROX3_HIGH: wr_byte = res_hold.prox3_result[15:8];
        srsr_pkg::SLOT_AUX_LOW:    wr_byte = res_hold.aux_result[7:0];
        srsr_pkg::SLOT_AUX_HIGH:   wr_byte = res_hold.aux_result[15:8];
        default:                   wr_byte = srsr_pkg::RESET_BYTE;
      endcase
    end else if (host_mem_wr) begin
      wr_go   = 1'b1;
      wr_slot = srsr_pkg::slot_of(host_req.addr);
      wr_byte = host_req.wdata;
    end
  end

  // byte memory holding the result and mailbox bytes
  srsr_byte_mem #(
    .DEPTH (srsr_pkg::BANK_DEPTH),
    .AW    (3)
  ) u_mem (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (wr_go),
    .wr_addr (wr_slot),
    .wr_data (wr_byte),
    .rd_addr (srsr_pkg::slot_of(host_req.addr)),
    .rd_data (mem_rdata)
  );

  // chip state byte, one-hot decode keeps at most one flag high
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      chip_power_state <= srsr_pkg::RESET_BYTE;
    end else begin
      chip_power_state <= srsr_pkg::RESET_BYTE;
      case (power_state)
        srsr_pkg::SRSR_PWR_AWAKE:   chip_power_state[srsr_pkg::BIT_AWAKE]   <= 1'b1;
        srsr_pkg::SRSR_PWR_SUSPEND: chip_power_state[srsr_pkg::BIT_SUSPEND] <= 1'b1;
        srsr_pkg::SRSR_PWR_SLEEP:   chip_power_state[srsr_pkg::BIT_SLEEP]   <= 1'b1;
        default: ;                                    // off: all flags clear
      endcase
    end
  end

  // remember what kind of read is in flight
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_pend <= 1'b0;
      rd_kind <= 2'h0;
    end else begin
      rd_pend <= host_req.rd;
      if (srsr_pkg::in_mem(host_req.addr)) begin
        rd_kind <= 2'h1;
      end else if (host_req.addr == srsr_pkg::ADDR_CHIP_POWER_STATE) begin
        rd_kind <= 2'h2;
      end else begin
        rd_kind <= 2'h0;                     // unmapped offsets read zero
      end
    end
  end

  // registered read answer, two cycles after the request
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      host_rdata  <= srsr_pkg::RESET_BYTE;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= rd_pend;
      case (rd_kind)
        2'h1:    host_rdata <= mem_rdata;
        2'h2:    host_rdata <= chip_power_state;
        default: host_rdata <= srsr_pkg::RESET_BYTE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* tb/srsr_regs_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// watches the register port and the power input of the bank
module srsr_regs_checker (
  input wire logic                     sys_clk,      // system clock
  input wire logic                     reset,        // sync reset
  input wire srsr_pkg::srsr_host_req_s host_req,     // host access
  input wire srsr_pkg::srsr_results_s  results,      // posted results
  input wire logic                     mailbox_wr,   // sequencer post
  input wire logic [7:0]               mailbox_data, // posted byte
  input wire srsr_pkg::srsr_pwr_e      power_state,  // power input
  input wire logic [7:0]               host_rdata,   // read byte
  input wire logic                     host_rvalid   // read valid
);
  logic [7:0] exp_state; // state byte the power input should give
  // one-hot decode of the power input
  always_comb begin
    case (power_state)
      srsr_pkg::SRSR_PWR_AWAKE:   exp_state = 8'h04;
      srsr_pkg::SRSR_PWR_SUSPEND: exp_state = 8'h02;
      srsr_pkg::SRSR_PWR_SLEEP:   exp_state = 8'h01;
      default:                    exp_state = 8'h00;
    endcase
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // host write then read back of the aux low byte
  property p_host_write;
    logic [7:0] d;
    (host_req.wr && host_req.addr == 8'h2c, d = host_req.wdata) ##2
      (host_req.rd && host_req.addr == 8'h2c) |-> ##2 host_rdata == d;
  endproperty
  // sequencer byte reaches the host after four quiet cycles
  property p_mailbox;
    logic [7:0] d;
    (mailbox_wr, d = mailbox_data) ##1 (!mailbox_wr && !host_req.wr)[*4] ##1
      (host_req.rd && host_req.addr == 8'h2e) |-> ##2 host_rdata == d;
  endproperty
  a_read_answer: assert property (host_req.rd |-> ##2 host_rvalid)
    else $error("read not answered two cycles later");
  a_valid_cause: assert property (host_rvalid |-> $past(host_req.rd, 2))
    else $error("read valid without a read");
  a_host_write: assert property (p_host_write)
    else $error("host write not read back");
  a_mailbox_path: assert property (p_mailbox)
    else $error("mailbox byte not read back");
  a_state_map: assert property (host_req.rd && host_req.addr == 8'h30 && $stable(power_state) &&
    !$past(reset) |-> ##2 host_rdata == $past(exp_state, 2)) else $error("state byte wrong");
  a_state_reserved: assert property (host_rvalid && $past(host_req.addr, 2) == 8'h30 |->
    host_rdata[7:3] == 5'h00) else $error("reserved state bits set");
  a_reset_zero: assert property (host_req.rd && $past(reset) |-> ##2 host_rdata == 8'h00)
    else $error("byte not zero after reset");
  a_flag_onehot: assert property (host_rvalid && $past(host_req.addr, 2) == 8'h30 |->
    $onehot0(host_rdata[2:0])) else $error("more than one power flag");
  c_state_read: cover property (host_req.rd && host_req.addr == 8'h30);
  c_mailbox: cover property (p_mailbox);
  c_result_post: cover property (results.aux_valid);
endmodule
`default_nettype wire

/* tb/srsr_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// host side of the register port, one access at a time
module srsr_host_model (
  input  wire logic                    sys_clk,     // system clock
  output var srsr_pkg::srsr_host_req_s host_req,    // access request
  input  wire logic [7:0]              host_rdata,  // read byte
  input  wire logic                    host_rvalid  // read valid
);
  initial host_req = '0;
  // drop strobes, scramble qualifiers so stale values are never trusted
  task automatic idle();
    host_req.rd = 1'b0;
    host_req.wr = 1'b0;
    host_req.addr = ~host_req.addr;
    host_req.wdata = ~host_req.wdata;
  endtask
  // byte write, strobe held for one edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] wdata);
    host_req.wr = 1'b1;
    host_req.addr = addr;
    host_req.wdata = wdata;
    @(negedge sys_clk);
    idle();
    @(negedge sys_clk);
  endtask
  // byte read, answer awaited for a bounded number of cycles
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    data = 8'hxx;
    host_req.rd = 1'b1;
    host_req.addr = addr;
    @(negedge sys_clk);
    idle();
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      if (host_rvalid === 1'b1) begin
        data = host_rdata;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

/* tb/sensor_result_status_regs_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module sensor_result_status_regs_bench;
  logic                     sys_clk = 1'b0;
  logic                     reset = 1'b1;
  srsr_pkg::srsr_host_req_s host_req;
  srsr_pkg::srsr_results_s  results = '0;
  logic                     mailbox_wr = 1'b0;
  logic [7:0]               mailbox_data = 8'h00;
  srsr_pkg::srsr_pwr_e      power_state = srsr_pkg::SRSR_PWR_OFF;
  logic [7:0]               host_rdata;
  logic                     host_rvalid;
  logic [7:0]               got;                                    // last read byte
  logic [7:0]               st_exp [4] = '{8'h00, 8'h01, 8'h02, 8'h04}; // state byte per power code
  int                       n_mismatch = 0;
  int                       tests_run = 0;
  initial forever #10 sys_clk = ~sys_clk;
  srsr_regs dut (.sys_clk(sys_clk), .reset(reset), .host_req(host_req), .results(results),
    .mailbox_wr(mailbox_wr), .mailbox_data(mailbox_data), .power_state(power_state),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid));
  srsr_host_model host (.sys_clk(sys_clk), .host_req(host_req), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid));
  // read one byte and compare
  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    host.rd(addr, got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // counts, verdict, end of run
  task automatic print_verdict();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    // every byte, the gap at 0x2f too, reads zero out of reset
    for (int a = 8'h29; a <= 8'h30; a++) rchk(8'(a), 8'h00);
    // post all three results, fetch them before anything new lands
    results = {1'b1, 16'h1234, 1'b1, 16'ha55a, 1'b1, 16'h0ff0};
    @(negedge sys_clk);
    results = {1'b0, 16'h1234, 1'b0, 16'ha55a, 1'b0, 16'h0ff0};
    repeat (20) @(negedge sys_clk);
    rchk(8'h29, 8'h12);
    rchk(8'h2a, 8'h5a);
    rchk(8'h2b, 8'ha5);
    rchk(8'h2c, 8'hf0);
    rchk(8'h2d, 8'h0f);
    host.wr(8'h2c, 8'h77);
    rchk(8'h2c, 8'h77);
    // sequencer posts a byte, host reads it after four quiet cycles
    mailbox_data = 8'h3c;
    mailbox_wr = 1'b1;
    @(negedge sys_clk);
    mailbox_wr = 1'b0;
    repeat (4) @(negedge sys_clk);
    rchk(8'h2e, 8'h3c);
    // every power code, with a write to the read-only byte first
    for (int i = 0; i < 4; i++) begin
      power_state = srsr_pkg::srsr_pwr_e'(i);
      repeat (2) @(negedge sys_clk);
      host.wr(8'h30, 8'hff);
      rchk(8'h30, st_exp[i]);
    end
    // second reset in mid-run clears the results
    reset = 1'b1;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    rchk(8'h2b, 8'h00);
    print_verdict();
  end
endmodule
bind srsr_regs srsr_regs_checker u_chk (.sys_clk(sys_clk), .reset(reset), .host_req(host_req),
  .results(results), .mailbox_wr(mailbox_wr), .mailbox_data(mailbox_data),
  .power_state(power_state), .host_rdata(host_rdata), .host_rvalid(host_rvalid));
`default_nettype wire
